// File: tuning_status_error_tracker_defines.vh
// Constants for the tuning status and fault tracker
`ifndef TUNING_STATUS_ERROR_TRACKER_DEFINES_VH
`define TUNING_STATUS_ERROR_TRACKER_DEFINES_VH

// Clock and time base
`define CLK_PERIOD_NS 40'd10
`define NS_PER_S 40'd1000000000
`define CYCLES_PER_S (`NS_PER_S / `CLK_PERIOD_NS)

// Persistence and wait times, in seconds
`define LASER_WAIT_S 40'd60
`define SYNC_LOSS_S (40'd10 * 40'd60)
`define RF_RANGE_S 40'd60
`define MINUTE_S 40'd60

// Times as clock cycles
`define LASER_WAIT_CYCLES (`LASER_WAIT_S * `CYCLES_PER_S)
`define SYNC_LOSS_CYCLES (`SYNC_LOSS_S * `CYCLES_PER_S)
`define RF_RANGE_CYCLES (`RF_RANGE_S * `CYCLES_PER_S)
`define MINUTE_CYCLES (`MINUTE_S * `CYCLES_PER_S)
`define TIMER_W 40

// Main state codes
`define MS_INITIAL 8'h00
`define MS_HALT 8'h02
`define MS_INIT 8'h03
`define MS_WARMING 8'h04
`define MS_CALIBRATION 8'h05
`define MS_READY 8'h06

// Calibration sub-state codes
`define SUB_FIRST 8'h00
`define SUB_LASER_WAIT 8'h03
`define SUB_LAST 8'h19
`define SUB_FAIL_BASE 8'h32
`define SUB_FAIL_LAST 8'h35

// System reset key, 1234 decimal
`define RESET_KEY 16'h04d2

// Fault word bit positions
`define FLT_SYNC_LOSS 0
`define FLT_RF_RANGE 1
`define FLT_TEC_PROT 2
`define FLT_RF_IDENT 6
`define FLT_RF_SENSOR 7

// Bits that may ever be set; all others read zero
`define FLT_LOW_MASK 8'hc7
`define FLT_UPPER_MASK 32'hc0cfc000
`define FAULT_RESET 32'h00000000

// Identification failure code that belongs to the RF control group
`define RF_IDENT_CODE 2'h0

`endif

// File: persist_timer.v
// Counts how long a condition has held and flags when it exceeds a limit
`timescale 1ns/1ps
`include "tuning_status_error_tracker_defines.vh"

module persist_timer #(
	parameter [`TIMER_W-1:0] LIMIT = 40'd100
) (
	// Clock and reset
	input wire sys_clk_in,
	input wire rst_in,
	// Watched condition
	input wire cond_in,
	// Condition held past the limit
	output wire expired_out
);

	reg [`TIMER_W-1:0] count_reg;
	reg [`TIMER_W-1:0] count_next;

	always @* begin
		if (!cond_in) begin
			count_next = {`TIMER_W{1'b0}};
		end else if (count_reg != LIMIT) begin
			count_next = count_reg + {{(`TIMER_W-1){1'b0}}, 1'b1};
		end else begin
			count_next = count_reg;
		end
	end

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			count_reg <= {`TIMER_W{1'b0}};
		end else begin
			count_reg <= count_next;
		end
	end

	// Fires on the cycle the condition is seen beyond LIMIT cycles
	assign expired_out = cond_in && (count_reg == LIMIT);

endmodule

// File: tuning_status_error_tracker.v
// Main-state, calibration sub-state, fault word and up-time tracker
`timescale 1ns/1ps
`include "tuning_status_error_tracker_defines.vh"

// What this block does
// - Calibration sub-state counts 0 to 25, 60 s wait
// - Identification failure parks sub-state at 50..53
// - Failed calibration holds until restart or reset
// - Persistent faults force the halt state
// - Sensor failure flags only, no state change
// - Fault bits sticky, cleared only in initial state
// - Reset command with key 1234 restarts, clears
// - Low byte holds transmitter RF control faults
// - Bit 0: sync lost over 10 min
// - Bit 1: RF input bad over 60 s
// - Bit 2: temperature sensor, cooler protection
// - Bit 6: RF control identification failed
// - Bit 7: RF control sensor failed
// - Up-time counts whole minutes since power-on
// - Main state codes 0,2,3,4,5,6
// - Upper fault groups come from upper_fault_in, masked by FLT_UPPER_MASK
module tuning_status_error_tracker #(
	parameter [`TIMER_W-1:0] LASER_WAIT_CYCLES = `LASER_WAIT_CYCLES,
	parameter [`TIMER_W-1:0] SYNC_LOSS_CYCLES = `SYNC_LOSS_CYCLES,
	parameter [`TIMER_W-1:0] RF_RANGE_CYCLES = `RF_RANGE_CYCLES,
	parameter [`TIMER_W-1:0] MINUTE_CYCLES = `MINUTE_CYCLES
) (
	// Clock and power-on reset
	input wire sys_clk_in,
	input wire rst_in,
	// Remote state request command
	input wire state_request_valid_in,
	input wire [7:0] state_request_command_in,
	// Remote system reset command
	input wire reset_cmd_valid_in,
	input wire [15:0] reset_key_in,
	// Progress of the start-up sequence
	input wire init_done_in,
	input wire warm_done_in,
	input wire step_ok_in,
	input wire ident_fail_in,
	input wire [1:0] ident_code_in,
	// Transmitter RF control fault sources
	input wire sync_lost_in,
	input wire rf_level_bad_in,
	input wire tec_protect_in,
	input wire rf_sensor_fail_in,
	// Fault events of the other three groups, bits 31:8
	input wire [23:0] upper_fault_in,
	// Status readback
	output wire [7:0] main_state_out,
	output wire [7:0] sub_state_out,
	output wire [31:0] fault_status_word_out,
	output wire [31:0] uptime_out
);

	reg [7:0] main_state_reg;
	reg [7:0] main_state_next;
	reg [7:0] sub_state_reg;
	reg [7:0] sub_state_next;
	reg [31:0] fault_reg;
	reg [31:0] fault_next;
	reg [31:0] fault_set;
	reg [31:0] uptime_reg;
	reg [31:0] uptime_next;
	reg [`TIMER_W-1:0] minute_cnt_reg;

	// Bits that may ever be set
	localparam [31:0] UPPER_MASK = `FLT_UPPER_MASK;
	localparam [7:0] LOW_MASK = `FLT_LOW_MASK;

	wire in_calib;
	wire laser_wait_active;
	wire fault_clear;
	wire rf_ident_event;
	wire minute_tick;
	wire laser_wait_done;
	wire sync_loss_expired;
	wire rf_range_expired;
	wire key_ok;
	wire start_req;
	wire halt_req;
	wire calib_failed;
	wire halt_fault;

	function is_state_request;
		input valid;
		input [7:0] cmd;
		input [7:0] code;
		begin
			is_state_request = valid && (cmd == code);
		end
	endfunction

	// Sub-state arithmetic
	function [7:0] sub_advance;
		input [7:0] sub;
		begin
			sub_advance = sub + 8'h01;
		end
	endfunction

	function [7:0] fail_sub;
		input [1:0] code;
		begin
			fail_sub = `SUB_FAIL_BASE + {6'h00, code};
		end
	endfunction

	function in_fail_range;
		input [7:0] sub;
		begin
			in_fail_range = (sub >= `SUB_FAIL_BASE) &&
				(sub <= `SUB_FAIL_LAST);
		end
	endfunction

	assign key_ok = reset_cmd_valid_in && (reset_key_in == `RESET_KEY);
	assign start_req = is_state_request(state_request_valid_in,
		state_request_command_in, `MS_INITIAL);
	assign halt_req = is_state_request(state_request_valid_in,
		state_request_command_in, `MS_HALT);
	assign calib_failed = in_fail_range(sub_state_reg);

	// Decoded state and timing conditions
	assign in_calib = (main_state_reg == `MS_CALIBRATION);
	assign laser_wait_active = in_calib &&
		(sub_state_reg == `SUB_LASER_WAIT);
	assign fault_clear = (main_state_reg == `MS_INITIAL);
	assign rf_ident_event = in_calib && !calib_failed && ident_fail_in &&
		(ident_code_in == `RF_IDENT_CODE);
	assign minute_tick = (minute_cnt_reg == MINUTE_CYCLES - 40'd1);

	// Faults whose outcome group is the halt state
	assign halt_fault = sync_loss_expired || rf_range_expired ||
		tec_protect_in;

	// Laser warm-up wait inside calibration
	persist_timer #(
		.LIMIT(LASER_WAIT_CYCLES)
	) u_laser_wait (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.cond_in(laser_wait_active),
		.expired_out(laser_wait_done)
	);

	// Link synchronisation loss persistence
	persist_timer #(
		.LIMIT(SYNC_LOSS_CYCLES)
	) u_sync_loss (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.cond_in(sync_lost_in),
		.expired_out(sync_loss_expired)
	);

	// RF input range persistence
	persist_timer #(
		.LIMIT(RF_RANGE_CYCLES)
	) u_rf_range (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.cond_in(rf_level_bad_in),
		.expired_out(rf_range_expired)
	);

	// Main state and calibration sub-state
	always @* begin
		main_state_next = main_state_reg;
		sub_state_next = sub_state_reg;
		if (key_ok) begin
			main_state_next = `MS_INITIAL;
			sub_state_next = `SUB_FIRST;
		end else if (main_state_reg == `MS_HALT) begin
			if (start_req) begin
				main_state_next = `MS_INITIAL;
				sub_state_next = `SUB_FIRST;
			end
		end else if (halt_req || halt_fault) begin
			main_state_next = `MS_HALT;
		end else begin
			case (main_state_reg)
			`MS_INITIAL: begin
				main_state_next = `MS_INIT;
				sub_state_next = `SUB_FIRST;
			end
			`MS_INIT: begin
				if (init_done_in) begin
					main_state_next = `MS_WARMING;
				end
			end
			`MS_WARMING: begin
				if (warm_done_in) begin
					main_state_next = `MS_CALIBRATION;
					sub_state_next = `SUB_FIRST;
				end
			end
			`MS_CALIBRATION: begin
				if (calib_failed) begin
					sub_state_next = sub_state_reg;
				end else if (ident_fail_in) begin
					sub_state_next = fail_sub(ident_code_in);
				end else if (sub_state_reg == `SUB_LASER_WAIT) begin
					if (laser_wait_done) begin
						sub_state_next = sub_advance(sub_state_reg);
					end
				end else if (step_ok_in) begin
					if (sub_state_reg == `SUB_LAST) begin
						main_state_next = `MS_READY;
					end else begin
						sub_state_next = sub_advance(sub_state_reg);
					end
				end
			end
			`MS_READY: begin
				main_state_next = `MS_READY;
			end
			default: begin
				main_state_next = `MS_INITIAL;
				sub_state_next = `SUB_FIRST;
			end
			endcase
		end
	end

	// Fault events of this cycle
	always @* begin
		fault_set = 32'h00000000;
		fault_set[`FLT_SYNC_LOSS] = sync_loss_expired;
		fault_set[`FLT_RF_RANGE] = rf_range_expired;
		fault_set[`FLT_TEC_PROT] = tec_protect_in;
		fault_set[`FLT_RF_IDENT] = rf_ident_event;
		fault_set[`FLT_RF_SENSOR] = rf_sensor_fail_in;
		fault_set[7:0] = fault_set[7:0] & LOW_MASK;
		fault_set[31:8] = upper_fault_in & UPPER_MASK[31:8];
	end

	// Sticky word; a new event in the clearing cycle survives
	always @* begin
		if (fault_clear) begin
			fault_next = fault_set;
		end else begin
			fault_next = fault_reg | fault_set;
		end
	end

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			main_state_reg <= `MS_INITIAL;
			sub_state_reg <= `SUB_FIRST;
		end else begin
			main_state_reg <= main_state_next;
			sub_state_reg <= sub_state_next;
		end
	end

	// Fault word register
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			fault_reg <= `FAULT_RESET;
		end else begin
			fault_reg <= fault_next;
		end
	end

	// Cycles within the current minute
	always @(posedge sys_clk_in) begin
		if (rst_in || minute_tick) begin
			minute_cnt_reg <= {`TIMER_W{1'b0}};
		end else begin
			minute_cnt_reg <= minute_cnt_reg + 40'd1;
		end
	end

	// Minutes since power-on; untouched by the reset command
	always @* begin
		if (minute_tick) begin
			uptime_next = uptime_reg + 32'h00000001;
		end else begin
			uptime_next = uptime_reg;
		end
	end

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			uptime_reg <= 32'h00000000;
		end else begin
			uptime_reg <= uptime_next;
		end
	end

	assign main_state_out = main_state_reg;
	assign sub_state_out = sub_state_reg;
	assign fault_status_word_out = fault_reg;
	assign uptime_out = uptime_reg;

endmodule

// File: tuning_status_error_tracker_properties.sv
// Concurrent checks on the tracker's status outputs
`timescale 1ns/1ps
module tuning_status_error_tracker_properties (
	// Clock and reset
	input wire sys_clk_in,
	input wire rst_in,
	// Commands and events
	input wire state_request_valid_in,
	input wire reset_cmd_valid_in,
	input wire [15:0] reset_key_in,
	input wire ident_fail_in,
	input wire [1:0] ident_code_in,
	input wire sync_lost_in,
	input wire rf_level_bad_in,
	input wire tec_protect_in,
	input wire rf_sensor_fail_in,
	// Status
	input wire [7:0] main_state_out,
	input wire [7:0] sub_state_out,
	input wire [31:0] fault_status_word_out,
	input wire [31:0] uptime_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	wire no_req = !state_request_valid_in && !reset_cmd_valid_in;
	wire quiet = no_req && !sync_lost_in && !rf_level_bad_in && !tec_protect_in;
	wire [7:0] ms = main_state_out;
	wire [7:0] ss = sub_state_out;
	wire [31:0] fw = fault_status_word_out;
	// Identification failure taken in a running calibration
	sequence s_id_fail;
		ident_fail_in && ms == 8'h05 && ss < 8'h32 && quiet;
	endsequence
	property p_reserved; (fw & 32'h3f303f38) == 32'h0; endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved set");
	property p_sticky;
		ms != 8'h00 ##1 ms != 8'h00 |-> (fw & $past(fw)) == $past(fw);
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("fault lost");
	property p_sensor; rf_sensor_fail_in |=> fw[7]; endproperty
	a_sensor: assert property (p_sensor)
		else $error("bit 7 missing");
	property p_ident;
		s_id_fail |=> ss == 8'h32 + $past(ident_code_in);
	endproperty
	a_ident: assert property (p_ident)
		else $error("bad fail code");
	property p_bit6;
		s_id_fail ##0 ident_code_in == 2'h0 |=> fw[6];
	endproperty
	a_bit6: assert property (p_bit6)
		else $error("bit 6 missing");
	property p_hold;
		ms == 8'h05 && ss >= 8'h32 && quiet |=> $stable(ss) && ms == 8'h05;
	endproperty
	a_hold: assert property (p_hold)
		else $error("fail not held");
	property p_tec;
		tec_protect_in && no_req |=> ms == 8'h02 && fw[2];
	endproperty
	a_tec: assert property (p_tec)
		else $error("no halt");
	property p_key;
		reset_cmd_valid_in && reset_key_in == 16'h04d2 |=> ms == 8'h00;
	endproperty
	a_key: assert property (p_key)
		else $error("key ignored");
	property p_uptime;
		$changed(uptime_out) |-> uptime_out == $past(uptime_out) + 32'h1;
	endproperty
	a_uptime: assert property (p_uptime)
		else $error("uptime jump");
endmodule

// File: tuning_status_error_tracker_tb.sv
// Self-checking bench for the tuning status and fault tracker
`timescale 1ns/1ps
module tuning_status_error_tracker_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg rq_v = 1'b0;
	reg [7:0] rq_c = 8'h00;
	reg key_v = 1'b0;
	reg [15:0] key = 16'h0000;
	reg step = 1'b0;
	reg ini = 1'b0;
	reg wrm = 1'b0;
	reg id_f = 1'b0;
	reg [1:0] id_c = 2'h0;
	reg sync = 1'b0;
	reg rfb = 1'b0;
	reg tec = 1'b0;
	reg sens = 1'b0;
	reg [23:0] up = 24'h000000;
	wire [7:0] ms;
	wire [7:0] ss;
	wire [31:0] fw;
	wire [31:0] upt;
	integer err_total = 0;
	integer checked = 0;
	integer ups = 0;
	tuning_status_error_tracker #(.LASER_WAIT_CYCLES(40'd5),
		.SYNC_LOSS_CYCLES(40'd20), .RF_RANGE_CYCLES(40'd8),
		.MINUTE_CYCLES(40'd10)) DUT (.sys_clk_in(clk), .rst_in(rst),
		.state_request_valid_in(rq_v), .state_request_command_in(rq_c),
		.reset_cmd_valid_in(key_v), .reset_key_in(key),
		.init_done_in(ini), .warm_done_in(wrm), .step_ok_in(step),
		.ident_fail_in(id_f), .ident_code_in(id_c), .sync_lost_in(sync),
		.rf_level_bad_in(rfb), .tec_protect_in(tec),
		.rf_sensor_fail_in(sens), .upper_fault_in(up),
		.main_state_out(ms), .sub_state_out(ss),
		.fault_status_word_out(fw), .uptime_out(upt));
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (!rst) ups <= ups + 1;
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task chk(input [39:0] seen, input [39:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task req(input [7:0] c);
		cyc(1);
		rq_c = c;
		rq_v = 1'b1;
		cyc(1);
		rq_v = 1'b0;
	endtask
	task rkey(input [15:0] k);
		cyc(1);
		key = k;
		key_v = 1'b1;
		cyc(1);
		key_v = 1'b0;
	endtask
	task fail(input [1:0] c);
		id_c = c;
		id_f = 1'b1;
		cyc(1);
		id_f = 1'b0;
	endtask
	task stp(input integer n);
		step = 1'b1;
		cyc(n);
		step = 1'b0;
	endtask
	task final_report;
		if (err_total == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		err_total = err_total + 1;
		final_report;
	end
	initial begin
		cyc(6);
		rst = 1'b0;
		cyc(1);
		chk(ms, 8'h03);
		cyc(1);
		chk(ms, 8'h03);
		ini = 1'b1;
		cyc(1);
		chk(ms, 8'h04);
		cyc(1);
		chk(ms, 8'h04);
		wrm = 1'b1;
		cyc(1);
		chk({ms, ss}, 16'h0500);
		stp(3);
		chk(ss, 8'h03);
		cyc(1);
		stp(2);
		chk(ss, 8'h03);
		cyc(2);
		chk(ss, 8'h03);
		cyc(1);
		chk(ss, 8'h04);
		stp(21);
		chk({ms, ss}, 16'h0519);
		cyc(1);
		stp(1);
		chk(ms, 8'h06);
		sens = 1'b1;
		cyc(1);
		sens = 1'b0;
		chk({ms, fw}, 40'h0600000080);
		up = 24'hffffff;
		cyc(1);
		up = 24'h000000;
		chk(fw, 32'hc0cfc080);
		req(8'h00);
		chk(ms, 8'h06);
		req(8'h02);
		chk({ms, fw}, 40'h02c0cfc080);
		req(8'h00);
		chk(ms, 8'h00);
		cyc(1);
		chk({ms, fw}, 40'h0300000000);
		cyc(2);
		stp(2);
		fail(2'h2);
		chk(ss, 8'h34);
		stp(2);
		chk({ms, ss}, 16'h0534);
		sens = 1'b1;
		cyc(1);
		sens = 1'b0;
		rkey(16'h04d3);
		chk({ms, fw}, 40'h0500000080);
		rkey(16'h04d2);
		chk(ms, 8'h00);
		cyc(1);
		chk({ms, fw}, 40'h0300000000);
		cyc(2);
		fail(2'h0);
		chk({ss, fw}, 40'h3200000040);
		tec = 1'b1;
		cyc(1);
		tec = 1'b0;
		chk({ms, fw}, 40'h0200000044);
		sync = 1'b1;
		cyc(15);
		sync = 1'b0;
		cyc(1);
		sync = 1'b1;
		cyc(15);
		chk(fw, 32'h44);
		cyc(10);
		sync = 1'b0;
		chk(fw, 32'h45);
		rfb = 1'b1;
		cyc(12);
		rfb = 1'b0;
		chk(fw, 32'h47);
		chk(upt, ups / 10);
		final_report;
	end
endmodule
bind tuning_status_error_tracker tuning_status_error_tracker_properties chk_i (.*);
